// *** pecl_pkg.sv ***
/*
 * Constants for the auxiliary edge, output disable, commit, password and filter gain registers.
 * Assumes a 100 MHz system clock and a 32-bit Avalon-MM slave port with byte addressing.
 */
package pecl_pkg;
	// Register indices; byte address is four times the index
	localparam logic [6:0] IDX_AUX_FALL_HIGH = 7'h5B;
	localparam logic [6:0] IDX_AUX_FALL_SET = 7'h5C;
	localparam logic [6:0] IDX_OUT_DISABLE = 7'h5D;
	localparam logic [6:0] IDX_PASSWORD = 7'h5E;
	localparam logic [6:0] IDX_SS_GAIN = 7'h5F;
	localparam logic [6:0] IDX_LF_GAIN = 7'h60;
	localparam int ADDR_W = 9;
	localparam int DATA_W = 32;
	localparam int TIME_W = 12;
	localparam int DRIVE_N = 7;
	// Field positions in the falling edge setting register
	localparam int SET_LSB_HI = 7;
	localparam int SET_LSB_LO = 4;
	localparam int SET_MOD_EN = 3;
	localparam int SET_SIGN = 2;
	localparam int SET_REG_AUX = 1;
	// Field positions in the disable register; bits 7..1 map onto drive 6..0
	localparam int DIS_COMMIT = 0;
	localparam int DRV_AUX = 6;
	// Reset values
	localparam logic [7:0] RST_AUX_FALL_HIGH = 8'h00;
	localparam logic [7:0] RST_AUX_FALL_SET = 8'h00;
	localparam logic [6:0] RST_OUT_DISABLE = 7'h00;
	localparam logic [1:0] RST_SS_GAIN = 2'h0;
	localparam logic [7:0] RST_LF_GAIN = 8'h00;
	// Power-on password before the first memory download; value is arbitrary
	localparam logic [7:0] RST_PASSWORD = 8'h00;
	// Timing and gain scaling
	localparam int CLK_MHZ = 100;
	localparam logic [15:0] EDGE_STEP_NS = 16'h0005;
	localparam logic [9:0] LF_STEP_DDB = 10'h003;
	localparam logic [9:0] LF_SPAN_DDB = 10'h0C8;
	typedef enum logic [1:0] {
		PECL_LOCKED = 2'b00,
		PECL_ONE_MATCH = 2'b01,
		PECL_UNLOCKED = 2'b10
	} pecl_lock_t;
endpackage

// *** pecl_pw_if.sv ***
/*
 * Carrier between the register bank and the password lock.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface pecl_pw_if;
	logic wr;
	logic [7:0] data;
	logic load;
	logic [7:0] load_pw;
	logic unlocked;
	modport ctl (output wr, output data, output load, output load_pw, input unlocked);
	modport lock (input wr, input data, input load, input load_pw, output unlocked);
endinterface
`default_nettype wire

// *** pecl_lock.sv ***
/*
 * Password lock for the nonvolatile memory.
 * Assumes write and load strobes are single-cycle pulses on the system clock.
 */
`timescale 1ns/100ps
`default_nettype none
module pecl_lock
	import pecl_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	pecl_pw_if.lock pw
);
	pecl_lock_t state_reg, state_next;
	logic [7:0] pw_reg, pw_next;
	logic unlocked_reg, unlocked_next;

	always_comb begin
		state_next = state_reg;
		pw_next = pw_reg;
		if (pw.load) begin
			// Download wins over a coincident write and always relocks
			pw_next = pw.load_pw; // RQ11
			state_next = PECL_LOCKED; // RQ11
		end else if (pw.wr) begin
			if (pw.data != pw_reg) begin
				state_next = PECL_LOCKED; // RQ13
			end else begin
				unique case (state_reg)
					PECL_LOCKED: state_next = PECL_ONE_MATCH; // RQ12
					PECL_ONE_MATCH: state_next = PECL_UNLOCKED; // RQ12
					PECL_UNLOCKED: state_next = PECL_UNLOCKED;
					default: state_next = PECL_LOCKED;
				endcase
			end
		end
		unlocked_next = (state_next == PECL_UNLOCKED);
	end

	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_reg <= PECL_LOCKED;
			pw_reg <= RST_PASSWORD;
			unlocked_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			pw_reg <= pw_next;
			unlocked_reg <= unlocked_next;
		end
	end

	assign pw.unlocked = unlocked_reg;

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!nrst_in);

	sequence s_match_wr;
		pw.wr && !pw.load && pw.data == pw_reg;
	endsequence

	// Any spacing between the two matches is legal, so the first match is read from the state
	chk_two_matches: assert property ( // RQ12
		(state_reg == PECL_ONE_MATCH) ##0 s_match_wr |=> pw.unlocked)
		else $error("two matching password writes did not unlock");
	chk_single_locked: assert property ( // RQ12
		(state_reg == PECL_LOCKED) ##0 s_match_wr |=> !pw.unlocked)
		else $error("one password write unlocked the memory");
	chk_mismatch_lock: assert property ( // RQ13
		pw.wr && !pw.load && pw.data != pw_reg |=> !pw.unlocked && state_reg == PECL_LOCKED)
		else $error("wrong password did not relock");
	chk_load_locks: assert property ( // RQ11
		pw.load |=> !pw.unlocked && pw_reg == $past(pw.load_pw))
		else $error("download did not lock and load password");
endmodule
`default_nettype wire

// *** pecl_regs.sv ***
/*
 * Register bank for the auxiliary falling edge, output disables, commit, password and loop gains.
 * Assumes a 32-bit Avalon-MM master that holds each request until waitrequest is low,
 * drive inputs that are active high, and a loop modulation word on the system clock.
 */
`timescale 1ns/100ps
`default_nettype none
// What this block does
// RQ1: Falling edge time is eight high plus four bits.
// RQ2: Each time step moves edge by 5 ns.
// RQ3: Modulate enable bit lets loop shift edge.
// RQ4: Sign bit chooses later or earlier shift.
// RQ5: Regulate bit set: loop uses auxiliary, blanking synced.
// RQ6: Regulate bit clear: loop uses main and rectifiers.
// RQ7: Software keeps reserved bit zero.
// RQ8: One disable bit per output, fixed order.
// RQ9: Commit bit latches staged timing registers together.
// RQ10: Commit also applies pending third voltage setting.
// RQ11: Password write-only, starts locked, reloaded on download.
// RQ12: Two matching password writes unlock memory.
// RQ13: Any mismatching password write relocks memory.
// RQ14: Soft start gain code selects 1, 2, 4, 8.
// RQ15: Low-frequency gain rises 0.3 dB per step; the code clamps lf_gain_ddb_out at LF_SPAN_DDB from code 67 up.
// RQ16: Disabled output held inactive regardless of timing.
module pecl_regs
	import pecl_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	// Avalon-MM slave
	input wire logic [pecl_pkg::ADDR_W-1:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [pecl_pkg::DATA_W-1:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [pecl_pkg::DATA_W-1:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// Loop and raw PWM drives
	input wire logic [pecl_pkg::TIME_W-1:0] loop_mod_in,
	input wire logic [pecl_pkg::DRIVE_N-1:0] drive_raw_in,
	// Memory download
	input wire logic nvm_load_in,
	input wire logic [7:0] nvm_password_in,
	// Auxiliary falling edge
	output logic [pecl_pkg::TIME_W-1:0] aux_fall_edge_time_out,
	output logic [15:0] aux_fall_delay_ns_out,
	output logic [pecl_pkg::TIME_W-1:0] aux_fall_edge_mod_out,
	output logic regulate_aux_out,
	output logic regulate_main_out,
	output logic blank_sync_aux_out,
	// Gated drives and commit
	output logic [pecl_pkg::DRIVE_N-1:0] drive_out,
	output logic commit_out,
	// Filter gains and lock
	output logic [3:0] ss_gain_out,
	output logic [7:0] lf_gain_code_out,
	output logic [9:0] lf_gain_ddb_out,
	output logic nvm_unlocked_out
);
	pecl_pw_if pw_bus();

	pecl_lock u_lock (
		.ref_clk_in(ref_clk_in),
		.nrst_in(nrst_in),
		.pw(pw_bus.lock)
	);

	// Bus slave: one wait cycle, then the answer
	logic wait_reg, wait_next;
	logic [DATA_W-1:0] rdata_reg, rdata_next;
	logic [6:0] idx;
	logic aligned;
	logic wr_take;
	logic [7:0] wbyte;

	assign idx = avs_address_in[ADDR_W-1:2];
	assign aligned = (avs_address_in[1:0] == 2'h0);
	assign wr_take = avs_write_in && !wait_reg && avs_byteenable_in[0] && aligned;
	assign wbyte = avs_writedata_in[7:0];

	// Staged and active configuration
	logic [7:0] high_reg, high_next;
	logic [7:0] set_reg, set_next;
	logic [6:0] dis_reg, dis_next;
	logic [1:0] ss_reg, ss_next;
	logic [7:0] lf_reg, lf_next;
	logic [TIME_W-1:0] act_time_reg, act_time_next;
	logic [3:0] act_flags_reg, act_flags_next;
	logic [6:0] act_dis_reg, act_dis_next;
	logic commit_reg, commit_next;
	logic commit_take;
	logic pw_wr_reg, pw_wr_next;
	logic [7:0] pw_data_reg, pw_data_next;

	assign commit_take = wr_take && idx == IDX_OUT_DISABLE && wbyte[DIS_COMMIT];

	always_comb begin
		wait_next = 1'b1;
		rdata_next = rdata_reg;
		if ((avs_read_in || avs_write_in) && wait_reg) begin
			wait_next = 1'b0;
		end
		if (avs_read_in && wait_reg) begin
			rdata_next = '0;
			if (aligned) begin
				unique case (idx)
					IDX_AUX_FALL_HIGH: rdata_next[7:0] = high_reg;
					IDX_AUX_FALL_SET: rdata_next[7:0] = set_reg;
					// Commit bit is write-only and reads zero
					IDX_OUT_DISABLE: rdata_next[7:0] = {dis_reg, 1'b0};
					IDX_SS_GAIN: rdata_next[7:0] = {6'h00, ss_reg};
					IDX_LF_GAIN: rdata_next[7:0] = lf_reg;
					// Password and unmapped words read zero
					default: rdata_next = '0;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wait_reg <= 1'b1;
			rdata_reg <= '0;
		end else begin
			wait_reg <= wait_next;
			rdata_reg <= rdata_next;
		end
	end

	always_comb begin
		high_next = high_reg;
		set_next = set_reg;
		dis_next = dis_reg;
		ss_next = ss_reg;
		lf_next = lf_reg;
		pw_wr_next = 1'b0;
		pw_data_next = pw_data_reg;
		act_time_next = act_time_reg;
		act_flags_next = act_flags_reg;
		act_dis_next = act_dis_reg;
		commit_next = 1'b0;
		if (wr_take) begin
			unique case (idx)
				IDX_AUX_FALL_HIGH: high_next = wbyte;
				// Reserved bit 0 is stored as written; software keeps it zero
				IDX_AUX_FALL_SET: set_next = wbyte; // RQ7
				IDX_OUT_DISABLE: dis_next = wbyte[7:1]; // RQ8
				IDX_PASSWORD: begin
					pw_wr_next = 1'b1; // RQ11
					pw_data_next = wbyte;
				end
				IDX_SS_GAIN: ss_next = wbyte[1:0];
				IDX_LF_GAIN: lf_next = wbyte;
				default: begin
				end
			endcase
		end
		// Active copy moves only on commit, so a retimed edge never mixes old and new halves
		if (commit_take) begin
			act_time_next = {high_reg, set_reg[SET_LSB_HI:SET_LSB_LO]}; // RQ1 RQ9
			act_flags_next = set_reg[3:0]; // RQ9
			act_dis_next = wbyte[7:1]; // RQ9
			commit_next = 1'b1; // RQ10
		end
	end

	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			high_reg <= RST_AUX_FALL_HIGH;
			set_reg <= RST_AUX_FALL_SET;
			dis_reg <= RST_OUT_DISABLE;
			ss_reg <= RST_SS_GAIN;
			lf_reg <= RST_LF_GAIN;
			pw_wr_reg <= 1'b0;
			pw_data_reg <= 8'h00;
			act_time_reg <= {RST_AUX_FALL_HIGH, RST_AUX_FALL_SET[SET_LSB_HI:SET_LSB_LO]};
			act_flags_reg <= RST_AUX_FALL_SET[3:0];
			act_dis_reg <= RST_OUT_DISABLE;
			commit_reg <= 1'b0;
		end else begin
			high_reg <= high_next;
			set_reg <= set_next;
			dis_reg <= dis_next;
			ss_reg <= ss_next;
			lf_reg <= lf_next;
			pw_wr_reg <= pw_wr_next;
			pw_data_reg <= pw_data_next;
			act_time_reg <= act_time_next;
			act_flags_reg <= act_flags_next;
			act_dis_reg <= act_dis_next;
			commit_reg <= commit_next;
		end
	end

	assign pw_bus.wr = pw_wr_reg;
	assign pw_bus.data = pw_data_reg;
	assign pw_bus.load = nvm_load_in;
	assign pw_bus.load_pw = nvm_password_in;

	// Output stage, all registered
	logic [TIME_W-1:0] time_q, time_d;
	logic [15:0] ns_q, ns_d;
	logic [TIME_W-1:0] mod_q, mod_d;
	logic reg_aux_q, reg_aux_d;
	logic [6:0] drv_q, drv_d;
	logic [3:0] ssg_q, ssg_d;
	logic [9:0] ddb_q, ddb_d;
	logic [TIME_W:0] mod_sum;
	logic [TIME_W:0] mod_diff;
	logic [9:0] ddb_raw;

	assign mod_sum = {1'b0, act_time_reg} + {1'b0, loop_mod_in};
	assign mod_diff = {1'b0, act_time_reg} - {1'b0, loop_mod_in};
	assign ddb_raw = 10'({2'h0, lf_reg} * LF_STEP_DDB);

	always_comb begin
		time_d = act_time_reg;
		ns_d = 16'({4'h0, act_time_reg} * EDGE_STEP_NS); // RQ2
		mod_d = act_time_reg; // RQ3
		if (act_flags_reg[SET_MOD_EN]) begin
			// Saturate instead of wrapping so the edge cannot jump across the period
			if (act_flags_reg[SET_SIGN]) begin
				mod_d = mod_sum[TIME_W] ? {TIME_W{1'b1}} : mod_sum[TIME_W-1:0]; // RQ4
			end else begin
				mod_d = mod_diff[TIME_W] ? '0 : mod_diff[TIME_W-1:0]; // RQ4
			end
		end
		reg_aux_d = act_flags_reg[SET_REG_AUX]; // RQ5 RQ6
		ssg_d = 4'(4'h1 << ss_reg); // RQ14
		ddb_d = (ddb_raw > LF_SPAN_DDB) ? LF_SPAN_DDB : ddb_raw; // RQ15
	end

	// Disabled drives are forced low whatever the edge generator does
	genvar gi;
	generate
		for (gi = 0; gi < DRIVE_N; gi++) begin : g_drive
			assign drv_d[gi] = drive_raw_in[gi] && !act_dis_reg[gi]; // RQ8 RQ16
		end
	endgenerate

	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			time_q <= '0;
			ns_q <= 16'h0000;
			mod_q <= '0;
			reg_aux_q <= 1'b0;
			drv_q <= 7'h00;
			ssg_q <= 4'h1;
			ddb_q <= 10'h000;
		end else begin
			time_q <= time_d;
			ns_q <= ns_d;
			mod_q <= mod_d;
			reg_aux_q <= reg_aux_d;
			drv_q <= drv_d;
			ssg_q <= ssg_d;
			ddb_q <= ddb_d;
		end
	end

	logic reg_main_q;
	logic blank_q;
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			reg_main_q <= 1'b1;
			blank_q <= 1'b0;
		end else begin
			reg_main_q <= !reg_aux_d; // RQ6
			blank_q <= reg_aux_d; // RQ5
		end
	end

	assign avs_readdata_out = rdata_reg;
	assign avs_waitrequest_out = wait_reg;
	assign aux_fall_edge_time_out = time_q;
	assign aux_fall_delay_ns_out = ns_q;
	assign aux_fall_edge_mod_out = mod_q;
	assign regulate_aux_out = reg_aux_q;
	assign regulate_main_out = reg_main_q;
	assign blank_sync_aux_out = blank_q;
	assign drive_out = drv_q;
	assign commit_out = commit_reg;
	assign ss_gain_out = ssg_q;
	assign lf_gain_code_out = lf_reg;
	assign lf_gain_ddb_out = ddb_q;
	assign nvm_unlocked_out = pw_bus.unlocked;

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!nrst_in);

	sequence s_commit_write;
		commit_take;
	endsequence
	sequence s_new_time_seen;
		##2 aux_fall_edge_time_out == $past({high_reg, set_reg[7:4]}, 2);
	endsequence

	chk_commit_latch: assert property (s_commit_write |-> s_new_time_seen) // RQ9
		else $error("commit did not present staged edge time");
	chk_commit_hold: assert property (!commit_take |=> $stable(act_time_reg)) // RQ9
		else $error("active edge time moved without commit");
	chk_commit_pulse: assert property (s_commit_write |=> commit_out ##1 !commit_out) // RQ10
		else $error("commit pulse wrong");
	chk_aux_disabled: assert property (act_dis_reg[DRV_AUX] |=> !drive_out[DRV_AUX]) // RQ16
		else $error("disabled auxiliary drive not held low");
	chk_mod_off: assert property ( // RQ3
		!act_flags_reg[SET_MOD_EN] |=> aux_fall_edge_mod_out == $past(act_time_reg))
		else $error("unmodulated edge moved");
	chk_mod_later: assert property ( // RQ4
		act_flags_reg[SET_MOD_EN] && act_flags_reg[SET_SIGN] && !mod_sum[TIME_W]
		|=> aux_fall_edge_mod_out == $past(act_time_reg) + $past(loop_mod_in))
		else $error("negative sign did not move edge later");
	chk_regulate_path: assert property ( // RQ5
		##1 regulate_aux_out == blank_sync_aux_out && regulate_aux_out != regulate_main_out)
		else $error("regulate selection inconsistent");
	chk_delay_ns: assert property ( // RQ2
		##1 aux_fall_delay_ns_out == 16'($past({4'h0, act_time_reg}) * EDGE_STEP_NS))
		else $error("edge delay not five ns per step");
	chk_ss_gain: assert property ( // RQ14
		##1 ss_gain_out == 4'(4'h1 << $past(ss_reg)))
		else $error("soft start gain decode wrong");
	chk_bus_answer: assert property ( // bus timing
		(avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
		else $error("bus answer not after one wait cycle");
endmodule
`default_nettype wire

// *** tb.sv ***
/*
 * Self-checking bench for the pecl_regs register slice.
 * Assumes pecl_pkg and the design files are compiled first; the bench is the only bus master.
 */
`timescale 1ns/100ps
`default_nettype none
module tb;
	import pecl_pkg::*;
	typedef struct {
		logic [8:0] addr;
		logic [7:0] wd;
		logic [11:0] mod;
		int sel;
		logic [31:0] exp;
	} pecl_row_t;
	logic ref_clk_in;
	logic nrst_in;
	logic [ADDR_W-1:0] addr;
	logic rd;
	logic wr;
	logic [DATA_W-1:0] wdata;
	logic [3:0] be;
	logic [DATA_W-1:0] rdata;
	logic wait_o;
	logic [TIME_W-1:0] loop_mod;
	logic [DRIVE_N-1:0] drv_raw;
	logic [DRIVE_N-1:0] drv;
	logic nvm_load;
	logic [7:0] nvm_pw;
	logic [TIME_W-1:0] t_act;
	logic [TIME_W-1:0] t_mod;
	logic [15:0] dly;
	logic reg_aux;
	logic reg_main;
	logic blank;
	logic commit;
	logic [3:0] ss;
	logic [7:0] lf_code;
	logic [9:0] lf_ddb;
	logic unlocked;
	logic [31:0] rv;
	int miscompares;
	int compares;
	// Ordinary cases: write, let the outputs settle, then compare one view
	pecl_row_t rows[25] = '{
		'{9'h16C, 8'hAB, 12'h000, 0, 32'hAB}, '{9'h170, 8'hC0, 12'h000, 0, 32'hC0},
		'{9'h170, 8'hC0, 12'h000, 4, 32'h0}, '{9'h174, 8'h01, 12'h000, 4, 32'hABC},
		'{9'h174, 8'h01, 12'h000, 5, 32'h35AC}, '{9'h170, 8'hCC, 12'h100, 6, 32'hABC},
		'{9'h174, 8'h01, 12'h100, 6, 32'hBBC}, '{9'h174, 8'h01, 12'hFFF, 6, 32'hFFF},
		'{9'h170, 8'hC8, 12'hFFF, 6, 32'hFFF}, '{9'h174, 8'h01, 12'h100, 6, 32'h9BC},
		'{9'h174, 8'h01, 12'hFFF, 6, 32'h0}, '{9'h170, 8'hC2, 12'h000, 7, 32'h2},
		'{9'h174, 8'h01, 12'h000, 7, 32'h5}, '{9'h170, 8'hC0, 12'h000, 7, 32'h5},
		'{9'h174, 8'h01, 12'h000, 7, 32'h2}, '{9'h17C, 8'h00, 12'h000, 1, 32'h1},
		'{9'h17C, 8'h01, 12'h000, 1, 32'h2}, '{9'h17C, 8'h02, 12'h000, 1, 32'h4},
		'{9'h17C, 8'h03, 12'h000, 1, 32'h8}, '{9'h180, 8'h05, 12'h000, 2, 32'hF},
		'{9'h180, 8'h42, 12'h000, 2, 32'hC6}, '{9'h180, 8'h43, 12'h000, 2, 32'hC8},
		'{9'h180, 8'hFF, 12'h000, 2, 32'hC8}, '{9'h180, 8'hFF, 12'h000, 3, 32'hFF},
		'{9'h180, 8'h07, 12'h000, 0, 32'h7}
	};

	pecl_regs dut (
		.ref_clk_in(ref_clk_in),
		.nrst_in(nrst_in),
		.avs_address_in(addr),
		.avs_read_in(rd),
		.avs_write_in(wr),
		.avs_writedata_in(wdata),
		.avs_byteenable_in(be),
		.avs_readdata_out(rdata),
		.avs_waitrequest_out(wait_o),
		.loop_mod_in(loop_mod),
		.drive_raw_in(drv_raw),
		.nvm_load_in(nvm_load),
		.nvm_password_in(nvm_pw),
		.aux_fall_edge_time_out(t_act),
		.aux_fall_delay_ns_out(dly),
		.aux_fall_edge_mod_out(t_mod),
		.regulate_aux_out(reg_aux),
		.regulate_main_out(reg_main),
		.blank_sync_aux_out(blank),
		.drive_out(drv),
		.commit_out(commit),
		.ss_gain_out(ss),
		.lf_gain_code_out(lf_code),
		.lf_gain_ddb_out(lf_ddb),
		.nvm_unlocked_out(unlocked)
	);

	task automatic final_report();
		if (miscompares == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Values read right after the edge are those the design showed at that edge
	task automatic bus(input logic is_wr, input logic [8:0] a, input logic [7:0] d,
		input logic [3:0] b, output logic [31:0] q);
		int n;
		@(posedge ref_clk_in);
		addr <= a;
		wdata <= {24'h000000, d};
		be <= b;
		wr <= is_wr;
		rd <= !is_wr;
		for (n = 0; n < 20; n++) begin
			@(posedge ref_clk_in);
			if (wait_o === 1'b0) begin
				break;
			end
		end
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		if (n == 20) begin
			chk("waitrequest", 32'h1, 32'h0);
			final_report();
		end
	endtask

	task automatic wr8(input logic [8:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, 4'hF, q);
	endtask

	task automatic rd_chk(input logic [8:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, 4'hF, q);
		chk("read", q, exp);
	endtask

	task automatic cyc(input int k);
		repeat (k) @(negedge ref_clk_in);
	endtask

	task automatic load_pw(input logic [7:0] pw);
		@(posedge ref_clk_in);
		nvm_pw <= pw;
		nvm_load <= 1'b1;
		@(posedge ref_clk_in);
		nvm_load <= 1'b0;
		cyc(3);
	endtask

	task automatic pw_chk(input logic [7:0] pw, input logic exp);
		wr8(9'h178, pw);
		cyc(3);
		chk("unlocked", {31'h0, unlocked}, {31'h0, exp});
	endtask

	// Reset must be low on entry; holds it for five edges in all
	task automatic rst_seq();
		cyc(2);
		chk("reset group a", {wait_o, reg_main, ss, t_act, drv, commit, unlocked, reg_aux, blank},
			{3'h0, 1'b1, 1'b1, 4'h1, 12'h000, 7'h00, 4'h0});
		chk("reset group b", {4'h0, dly, t_mod}, 32'h0);
		chk("reset group c", {14'h0, lf_code, lf_ddb}, 32'h0);
		repeat (3) @(posedge ref_clk_in);
		nrst_in <= 1'b1;
		cyc(2);
		chk("drive after reset", {25'h0, drv}, {25'h0, drv_raw});
	endtask

	initial begin
		ref_clk_in = 1'b0;
		forever #5 ref_clk_in = ~ref_clk_in;
	end

	initial begin
		nrst_in = 1'b0;
		addr = '0;
		rd = 1'b0;
		wr = 1'b0;
		wdata = '0;
		be = 4'h0;
		loop_mod = 12'h000;
		drv_raw = 7'h2A;
		nvm_load = 1'b0;
		nvm_pw = 8'h00;
		miscompares = 0;
		compares = 0;
		rst_seq();
		foreach (rows[i]) begin
			@(posedge ref_clk_in);
			loop_mod <= rows[i].mod;
			wr8(rows[i].addr, rows[i].wd);
			cyc(4);
			case (rows[i].sel)
				0: rd_chk(rows[i].addr, rows[i].exp);
				1: chk("ss_gain", {28'h0, ss}, rows[i].exp);
				2: chk("lf_ddb", {22'h0, lf_ddb}, rows[i].exp);
				3: chk("lf_code", {24'h0, lf_code}, rows[i].exp);
				4: chk("edge_time", {20'h0, t_act}, rows[i].exp);
				5: chk("delay_ns", {16'h0, dly}, rows[i].exp);
				6: chk("mod_edge", {20'h0, t_mod}, rows[i].exp);
				default: chk("regulate", {29'h0, reg_aux, reg_main, blank}, rows[i].exp);
			endcase
		end
		// Commit is a single pulse, high for the one cycle that starts at the accepting edge
		wr8(9'h174, 8'h01);
		cyc(1);
		chk("commit pulse", {31'h0, commit}, 32'h1);
		cyc(1);
		chk("commit end", {31'h0, commit}, 32'h0);
		// Each disable bit gates exactly one drive
		@(posedge ref_clk_in);
		drv_raw <= 7'h7F;
		for (int i = 1; i < 8; i++) begin
			wr8(9'h174, (8'h01 << i) | 8'h01);
			cyc(3);
			chk("drive gate", {25'h0, drv}, {25'h0, 7'h7F & ~(7'h01 << (i - 1))});
		end
		wr8(9'h174, 8'hFE);
		cyc(3);
		chk("staged disable", {25'h0, drv}, 32'h3F);
		chk("no commit", {31'h0, commit}, 32'h0);
		@(posedge ref_clk_in);
		drv_raw <= 7'h55;
		cyc(3);
		chk("held inactive", {25'h0, drv}, 32'h15);
		wr8(9'h174, 8'h01);
		cyc(3);
		chk("enabled again", {25'h0, drv}, 32'h55);
		// Refused accesses leave state alone and read as zero
		begin
			logic [31:0] q;
			bus(1'b1, 9'h16C, 8'h11, 4'h0, q);
			bus(1'b1, 9'h16D, 8'h22, 4'hF, q);
		end
		rd_chk(9'h16C, 32'hAB);
		rd_chk(9'h16D, 32'h0);
		rd_chk(9'h184, 32'h0);
		rd_chk(9'h178, 32'h0);
		rd_chk(9'h174, 32'h0);
		// Password lock: two matches unlock, any mismatch or download relocks
		load_pw(8'h5A);
		chk("locked at load", {31'h0, unlocked}, 32'h0);
		pw_chk(8'h5A, 1'b0);
		pw_chk(8'h11, 1'b0);
		pw_chk(8'h5A, 1'b0);
		pw_chk(8'h5A, 1'b1);
		pw_chk(8'h5A, 1'b1);
		pw_chk(8'h3C, 1'b0);
		pw_chk(8'h5A, 1'b0);
		pw_chk(8'h5A, 1'b1);
		load_pw(8'h5A);
		chk("relock on load", {31'h0, unlocked}, 32'h0);
		// Reset in mid-run restores every register
		@(posedge ref_clk_in);
		nrst_in <= 1'b0;
		rst_seq();
		rd_chk(9'h16C, 32'h0);
		rd_chk(9'h170, 32'h0);
		final_report();
	end
endmodule
`default_nettype wire
